// ===== verilog/lst_standby_trap.sv
/*
  local standby and access trap block: trap and standby enables, sticky status,
  reload control, six idle timers and the management interrupt request, behind an
  ahb-lite slave.
  assumes access_hit comes pre-decoded from the address decoders on clk_sys, one
  cycle per hit, and that the dma acknowledge lines are asynchronous pins.
*/
module lst_standby_trap
  import lst_pkg::*;
#(
  parameter longint unsigned TICK_PERIOD = TICK_CYCLES
)
(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [5:0]  access_hit,
  input  wire logic        board_dma_ack_two,
  input  wire logic        board_dma_ack_one,
  output logic             system_mgmt_interrupt,
  output logic             trap_request
);

  // software-visible registers
  logic [5:0] trap_enable;
  logic [5:0] trap_status;
  logic [5:0] standby_enable;
  logic [7:0] standby_reload_enable;
  logic [5:0] standby_status;
  logic [7:0] idle_count [GROUPS];
  logic       global_interrupt_enable;
  logic       freeze;

  // bus slave
  logic       wr_pend;
  logic [9:0] wr_idx;
  logic       addr_phase;
  logic       wr_now;
  logic [7:0] wbyte;

  // hsize is not checked: only word transfers are expected
  assign addr_phase = hsel && hready && htrans[1];
  assign wr_now     = wr_pend;
  assign wbyte      = hwdata[7:0];

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_pend <= 1'b0;
      wr_idx  <= 10'h000;
    end
    else if (ce)
    begin
      wr_pend <= addr_phase && hwrite;
      if (addr_phase)
        wr_idx <= haddr[11:2];
    end
  end

  // zero-wait slave, always okay
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else if (ce)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  function automatic logic wr_hit(input logic [9:0] idx);
    return wr_now && (wr_idx == idx);
  endfunction

  // dma acknowledge synchronisers
  logic [1:0] dma_two_sync;
  logic [1:0] dma_one_sync;
  logic       dma_two_prev;
  logic       dma_one_prev;
  logic       dma_two_edge;
  logic       dma_one_edge;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      dma_two_sync <= 2'b00;
      dma_one_sync <= 2'b00;
      dma_two_prev <= 1'b0;
      dma_one_prev <= 1'b0;
    end
    else if (ce)
    begin
      dma_two_sync <= {dma_two_sync[0], board_dma_ack_two};
      dma_one_sync <= {dma_one_sync[0], board_dma_ack_one};
      dma_two_prev <= dma_two_sync[1];
      dma_one_prev <= dma_one_sync[1];
    end
  end

  // a held acknowledge counts as one activity, not one per cycle
  assign dma_two_edge = dma_two_sync[1] && !dma_two_prev;
  assign dma_one_edge = dma_one_sync[1] && !dma_one_prev;

  // trap and reload events
  logic [5:0] trap_set;
  logic [5:0] idle_expired;
  logic [5:0] idle_set;
  logic [5:0] timer_reload;
  logic       reload_all;
  logic       audio_dma_reload;
  logic [5:0] enable_load;

  assign trap_set = access_hit & trap_enable;

  assign reload_all = |(access_hit & standby_reload_enable[RELOAD_GRP_BASE +: GROUPS]);

  assign audio_dma_reload = (dma_two_edge && standby_reload_enable[RELOAD_DMA_TWO])
                         || (dma_one_edge && standby_reload_enable[RELOAD_DMA_ONE]);

  assign enable_load = wr_hit(IDX_STANDBY_ENABLE) ? wbyte[5:0] : 6'h00;

  always_comb
  begin
    for (int g = 0; g < GROUPS; g++)
    begin
      timer_reload[g] = access_hit[g] || reload_all || enable_load[g];
    end
    timer_reload[GRP_AUDIO] = timer_reload[GRP_AUDIO] || audio_dma_reload;
  end

  assign idle_set = global_interrupt_enable ? idle_expired : 6'h00;

  // idle timers
  logic       idle_tick;

  lst_tick_gen #(
    .PERIOD (TICK_PERIOD)
  ) u_tick (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .ce      (ce),
    .freeze  (freeze),
    .tick    (idle_tick)
  );

  generate
    for (genvar g = 0; g < GROUPS; g++)
    begin : g_timer
      lst_timer_if tif ();

      assign tif.reload     = timer_reload[g];
      assign tif.run        = standby_enable[g] && !freeze;
      assign tif.tick       = idle_tick;
      // zero count expires at first tick
      assign tif.load_value = idle_count[g];
      assign idle_expired[g] = tif.expired;

      lst_idle_timer u_timer (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .ce      (ce),
        .tif     (tif)
      );
    end
  endgenerate

  // control registers
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      trap_enable <= RST_GROUPS;
    else if (ce && wr_hit(IDX_TRAP_ENABLE))
      trap_enable <= wbyte[5:0];
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      standby_enable <= RST_GROUPS;
    else if (ce && wr_hit(IDX_STANDBY_ENABLE))
      standby_enable <= wbyte[5:0];
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      standby_reload_enable <= RST_REG8;
    else if (ce && wr_hit(IDX_STANDBY_RELOAD))
      standby_reload_enable <= wbyte;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      global_interrupt_enable <= 1'b0;
      freeze                  <= 1'b0;
    end
    else if (ce && wr_hit(IDX_MGMT_CONTROL))
    begin
      global_interrupt_enable <= wbyte[CTL_GLOBAL_EN];
      freeze                  <= wbyte[CTL_FREEZE];
    end
  end

  logic [9:0] count_idx [GROUPS];

  assign count_idx[GRP_DISK]      = IDX_DISK_IDLE_COUNT;
  assign count_idx[GRP_AUDIO]     = IDX_AUDIO_IDLE_COUNT;
  assign count_idx[GRP_SERIAL]    = IDX_SERIAL_IDLE_CNT;
  assign count_idx[GRP_DEV_THREE] = IDX_DEV_THR_IDLE_CNT;
  assign count_idx[GRP_DEV_TWO]   = IDX_DEV_TWO_IDLE_CNT;
  assign count_idx[GRP_DEV_ONE]   = IDX_DEV_ONE_IDLE_CNT;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int g = 0; g < GROUPS; g++)
        idle_count[g] <= RST_REG8;
    end
    else if (ce)
    begin
      for (int g = 0; g < GROUPS; g++)
        if (wr_hit(count_idx[g]))
          idle_count[g] <= wbyte;
    end
  end

  // sticky status
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      trap_status <= RST_GROUPS;
    else if (ce)
    begin
      if (wr_hit(IDX_TRAP_STATUS))
        trap_status <= (trap_status & wbyte[5:0]) | trap_set;
      else
        trap_status <= trap_status | trap_set;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      standby_status <= RST_GROUPS;
    else if (ce)
    begin
      if (wr_hit(IDX_STANDBY_STATUS))
        standby_status <= (standby_status & wbyte[5:0]) | idle_set;
      else
        standby_status <= standby_status | idle_set;
    end
  end

  // interrupt request
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      system_mgmt_interrupt <= 1'b0;
      trap_request          <= 1'b0;
    end
    else if (ce)
    begin
      trap_request          <= |trap_set;
      system_mgmt_interrupt <= (|trap_set) || (|idle_set);
    end
  end

  // read mux
  logic [7:0] rd_byte;
  logic [9:0] rd_idx;

  assign rd_idx = haddr[11:2];

  always_comb
  begin
    rd_byte = 8'h00;
    unique case (rd_idx)
      IDX_TRAP_ENABLE:      rd_byte = {2'b00, trap_enable};
      IDX_TRAP_STATUS:      rd_byte = {2'b00, trap_status};
      IDX_STANDBY_ENABLE:   rd_byte = {2'b00, standby_enable};
      IDX_STANDBY_RELOAD:   rd_byte = standby_reload_enable;
      IDX_STANDBY_STATUS:   rd_byte = {2'b00, standby_status};
      IDX_DISK_IDLE_COUNT:  rd_byte = idle_count[GRP_DISK];
      IDX_AUDIO_IDLE_COUNT: rd_byte = idle_count[GRP_AUDIO];
      IDX_SERIAL_IDLE_CNT:  rd_byte = idle_count[GRP_SERIAL];
      IDX_DEV_ONE_IDLE_CNT: rd_byte = idle_count[GRP_DEV_ONE];
      IDX_DEV_TWO_IDLE_CNT: rd_byte = idle_count[GRP_DEV_TWO];
      IDX_DEV_THR_IDLE_CNT: rd_byte = idle_count[GRP_DEV_THREE];
      IDX_MGMT_CONTROL:     rd_byte = {6'h00, freeze, global_interrupt_enable};
      default:              rd_byte = 8'h00;
    endcase
  end

  // read data is sampled in the address phase; legal because the master idles the
  // bus during each data phase, so no write can land in between
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      hrdata <= 32'h0000_0000;
    else if (ce && addr_phase && !hwrite)
      hrdata <= {24'h00_0000, rd_byte};
  end
endmodule

// ===== verilog/lst_pkg.sv
/*
  constants shared by the local standby and trap block: register word indices, field
  positions, reset values and the idle tick timing.
  assumes a 125 mhz system clock and word-aligned ahb-lite register access.
*/
package lst_pkg;

  // number of watched address groups: disk, audio, serial, device 3, 2, 1
  localparam int unsigned GROUPS = 6;

  // group bit positions, shared by trap, standby and status registers
  localparam int unsigned GRP_DISK      = 5;
  localparam int unsigned GRP_AUDIO     = 4;
  localparam int unsigned GRP_SERIAL    = 3;
  localparam int unsigned GRP_DEV_THREE = 2;
  localparam int unsigned GRP_DEV_TWO   = 1;
  localparam int unsigned GRP_DEV_ONE   = 0;

  // register word indices; byte address is four times the index
  localparam logic [9:0] IDX_TRAP_ENABLE      = 10'h0ab;
  localparam logic [9:0] IDX_TRAP_STATUS      = 10'h0ae;
  localparam logic [9:0] IDX_STANDBY_ENABLE   = 10'h0b0;
  localparam logic [9:0] IDX_STANDBY_RELOAD   = 10'h0b1;
  localparam logic [9:0] IDX_STANDBY_STATUS   = 10'h0b2;
  localparam logic [9:0] IDX_DISK_IDLE_COUNT  = 10'h0b4;
  localparam logic [9:0] IDX_AUDIO_IDLE_COUNT = 10'h0b5;
  localparam logic [9:0] IDX_SERIAL_IDLE_CNT  = 10'h0b6;
  localparam logic [9:0] IDX_DEV_ONE_IDLE_CNT = 10'h0b8;
  localparam logic [9:0] IDX_DEV_TWO_IDLE_CNT = 10'h0b9;
  localparam logic [9:0] IDX_DEV_THR_IDLE_CNT = 10'h0ba;
  localparam logic [9:0] IDX_MGMT_CONTROL     = 10'h0c1;

  // reload enable: group g reloads everything through bit g + RELOAD_GRP_BASE
  localparam int unsigned RELOAD_GRP_BASE  = 2;
  localparam int unsigned RELOAD_DMA_TWO   = 1;
  localparam int unsigned RELOAD_DMA_ONE   = 0;

  // management control fields
  localparam int unsigned CTL_GLOBAL_EN = 0;
  localparam int unsigned CTL_FREEZE    = 1;

  // reset values
  localparam logic [7:0] RST_REG8   = 8'h00;
  localparam logic [5:0] RST_GROUPS = 6'h00;

  // idle tick: 8 s at 125 mhz
  localparam longint unsigned CLK_HZ        = 125_000_000;
  localparam longint unsigned TICK_PERIOD_S = 8;
  localparam longint unsigned TICK_CYCLES   = TICK_PERIOD_S * CLK_HZ;

endpackage

// ===== verilog/lst_timer_if.sv
/*
  interface between the register block and one idle timer.
  assumes both ends run on clk_sys.
*/
interface lst_timer_if;
  logic       reload;
  logic       run;
  logic       tick;
  logic [7:0] load_value;
  logic [7:0] count;
  logic       active;
  logic       expired;

  modport ctrl  (output reload, output run, output tick, output load_value,
                 input count, input active, input expired);
  modport timer (input reload, input run, input tick, input load_value,
                 output count, output active, output expired);
endinterface

// ===== verilog/lst_tick_gen.sv
/*
  free divider that makes the one-cycle idle tick.
  assumes freeze and ce come from logic on clk_sys.
*/
module lst_tick_gen
  import lst_pkg::*;
#(
  parameter longint unsigned PERIOD = TICK_CYCLES
)
(
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic ce,
  input  wire logic freeze,
  output logic      tick
);
  localparam int unsigned W = $clog2(PERIOD + 1);

  logic [W-1:0] cnt;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt  <= '0;
      tick <= 1'b0;
    end
    else if (ce)
    begin
      tick <= 1'b0;
      // a frozen divider keeps its phase so the first idle tick is not early
      if (!freeze)
      begin
        if (cnt == W'(PERIOD - 1))
        begin
          cnt  <= '0;
          tick <= 1'b1;
        end
        else
          cnt <= cnt + W'(1);
      end
    end
  end
endmodule

// ===== verilog/lst_idle_timer.sv
/*
  one 8-bit idle countdown timer.
  assumes reload, run and tick are driven by the register block on clk_sys.
*/
module lst_idle_timer
(
  input  wire logic   clk_sys,
  input  wire logic   resetn,
  input  wire logic   ce,
  lst_timer_if.timer  tif
);
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      tif.count   <= 8'h00;
      tif.active  <= 1'b0;
      tif.expired <= 1'b0;
    end
    else if (ce)
    begin
      tif.expired <= 1'b0;
      if (tif.reload)
      begin
        tif.count  <= tif.load_value;
        tif.active <= 1'b1;
      end
      else if (tif.run && tif.tick && tif.active)
      begin
        if (tif.count <= 8'h01)
        begin
          tif.count   <= 8'h00;
          tif.active  <= 1'b0;
          tif.expired <= 1'b1;
        end
        else
          tif.count <= tif.count - 8'h01;
      end
    end
  end
endmodule

// ===== tb/lst_standby_trap_chk.sv
/*
  concurrent checks on the ports of the standby and trap block.
  assumes hready is fed back from hreadyout; every check except trap_cause_a is gated by ce where state moves.
*/
module lst_standby_trap_chk
  import lst_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [5:0]  access_hit,
  input wire logic        system_mgmt_interrupt,
  input wire logic        trap_request
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       arm_wr;
  logic [5:0] arm_shadow;
  wire logic  take;
  wire logic  rd_status;

  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  assign take      = hsel && hready && htrans[1] && ce;
  assign rd_status = take && !hwrite && (haddr[11:2] == IDX_TRAP_STATUS
                     || haddr[11:2] == IDX_STANDBY_STATUS);

  // shadow of the trap arming bits, updated when the write data phase ends
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      arm_wr     <= 1'b0;
      arm_shadow <= 6'h00;
    end
    else if (ce)
    begin
      if (arm_wr)
        arm_shadow <= hwdata[5:0];
      arm_wr <= take && hwrite && haddr[11:2] == IDX_TRAP_ENABLE;
    end
  end

  trap_arm_a:
    assert property (ce && (access_hit & arm_shadow) != 6'h00 |=> trap_request)
    else $error("armed hit gave no trap request");
  trap_quiet_a:
    assert property (ce && (access_hit & arm_shadow) == 6'h00 |=> !trap_request)
    else $error("trap request without an armed hit");
  trap_smi_a:
    assert property (trap_request |-> system_mgmt_interrupt)
    else $error("trap request without management interrupt");
  trap_cause_a:
    assert property (trap_request |-> $past(access_hit) != 6'h00)
    else $error("trap request not in step with an access");
  rsvd_zero_a:
    assert property (rd_status |=> hrdata[31:6] == 26'h0000000)
    else $error("reserved status bits read nonzero");
  unmapped_a:
    assert property (take && !hwrite && haddr[11:2] == 10'h0ac |=> hrdata == 32'h00000000)
    else $error("unmapped read returned data");
  bus_ready_a:
    assert property (hreadyout)
    else $error("slave inserted a wait state");
  bus_okay_a:
    assert property (!hresp)
    else $error("slave answered with an error");
endmodule

// ===== tb/lst_host_model.sv
/*
  model of the host bridge side: decoded group hits and board dma acknowledges.
  assumes its tasks are called from the bench on clk_sys.
*/
module lst_host_model
(
  input  wire logic clk_sys,
  output logic [5:0] access_hit,
  output logic       board_dma_ack_two,
  output logic       board_dma_ack_one
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    access_hit        = 6'h00;
    board_dma_ack_two = 1'b0;
    board_dma_ack_one = 1'b0;
  end

  task automatic hit(input logic [5:0] m);
    @(posedge clk_sys);
    access_hit <= m;
    @(posedge clk_sys);
    access_hit <= 6'h00;
  endtask

  task automatic dma(input logic two);
    @(posedge clk_sys);
    if (two)
      board_dma_ack_two <= 1'b1;
    else
      board_dma_ack_one <= 1'b1;
    repeat (3) @(posedge clk_sys);
    board_dma_ack_two <= 1'b0;
    board_dma_ack_one <= 1'b0;
  endtask
endmodule

// ===== tb/test_local_standby_trap_smi.sv
/*
  self-checking bench for the standby and trap block.
  assumes a short tick period so idle timeouts take tens of cycles.
*/
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module test_local_standby_trap_smi
  import lst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int P = 20;
  logic        clk_sys, resetn, ce, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [5:0]  access_hit;
  logic        board_dma_ack_two, board_dma_ack_one;
  logic        system_mgmt_interrupt, trap_request;
  logic [7:0]  q;
  int          fails, total_checks, smi_n;

  lst_standby_trap #(.TICK_PERIOD(P)) i_dut (.clk_sys, .resetn, .ce, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
    .access_hit, .board_dma_ack_two, .board_dma_ack_one, .system_mgmt_interrupt,
    .trap_request);
  lst_host_model i_host (.clk_sys, .access_hit, .board_dma_ack_two, .board_dma_ack_one);

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
    if (system_mgmt_interrupt === 1'b1)
      smi_n++;

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {20'h00000, a, 2'b00};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h000000, d};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    q = hrdata[7:0];
  endtask

  task automatic chk_rd(input logic [9:0] a, input logic [7:0] e, input string n);
    bus(1'b0, a, 8'h00);
    `CHK(n, e, q)
  endtask

  task automatic t_regs;
    logic [9:0] ix [9] = '{IDX_DISK_IDLE_COUNT, IDX_AUDIO_IDLE_COUNT, IDX_SERIAL_IDLE_CNT,
      IDX_DEV_ONE_IDLE_CNT, IDX_DEV_TWO_IDLE_CNT, IDX_DEV_THR_IDLE_CNT, IDX_TRAP_ENABLE,
      IDX_STANDBY_ENABLE, IDX_STANDBY_RELOAD};
    chk_rd(IDX_TRAP_STATUS, 8'h00, "trap status reset");
    chk_rd(IDX_STANDBY_STATUS, 8'h00, "standby status reset");
    for (int i = 0; i < 9; i++)
    begin
      chk_rd(ix[i], 8'h00, "reset value");
      bus(1'b1, ix[i], 8'hf7 - 8'(i));
    end
    for (int i = 0; i < 9; i++)
    begin
      chk_rd(ix[i], (8'hf7 - 8'(i)) & (i inside {6, 7} ? 8'h3f : 8'hff), "read back");
      if (i > 5)
        bus(1'b1, ix[i], 8'h00);
    end
    bus(1'b1, 10'h0ac, 8'h5a);
    chk_rd(10'h0ac, 8'h00, "unmapped");
  endtask

  task automatic t_trap;
    int n0;
    for (int g = 0; g < GROUPS; g++)
    begin
      bus(1'b1, IDX_TRAP_ENABLE, 8'(1 << g));
      n0 = smi_n;
      i_host.hit(6'h3f);
      cyc(2);
      `CHK("trap smi", 1, smi_n - n0)
      chk_rd(IDX_TRAP_STATUS, 8'((2 << g) - 1), "trap status");
    end
    bus(1'b1, IDX_TRAP_STATUS, 8'hff);
    chk_rd(IDX_TRAP_STATUS, 8'h3f, "status kept");
    for (int g = 0; g < GROUPS; g++)
    begin
      bus(1'b1, IDX_TRAP_STATUS, ~8'(1 << g));
      chk_rd(IDX_TRAP_STATUS, 8'h3f & (8'hfe << g), "status clear");
    end
    // hit lands in the data phase of the clearing write
    fork
      bus(1'b1, IDX_TRAP_STATUS, 8'h00);
      begin
        @(posedge clk_sys);
        i_host.hit(6'h20);
      end
    join
    chk_rd(IDX_TRAP_STATUS, 8'h20, "set over clear");
    bus(1'b1, IDX_TRAP_STATUS, 8'h00);
    bus(1'b1, IDX_TRAP_ENABLE, 8'h00);
  endtask

  // with ce low neither the bus write nor the hit may move any state
  task automatic t_hold;
    int n0;
    bus(1'b1, IDX_TRAP_ENABLE, 8'h3f);
    n0 = smi_n;
    ce <= 1'b0;
    bus(1'b1, IDX_TRAP_ENABLE, 8'h00);
    i_host.hit(6'h3f);
    ce <= 1'b1;
    `CHK("frozen trap", 0, smi_n - n0)
    chk_rd(IDX_TRAP_ENABLE, 8'h3f, "frozen write");
    chk_rd(IDX_TRAP_STATUS, 8'h00, "frozen status");
    bus(1'b1, IDX_TRAP_ENABLE, 8'h00);
  endtask

  task automatic t_expire;
    int n0;
    bus(1'b1, IDX_AUDIO_IDLE_COUNT, 8'h02);
    n0 = smi_n;
    bus(1'b1, IDX_STANDBY_ENABLE, 8'h10);
    cyc(3 * P);
    `CHK("ungated smi", 0, smi_n - n0)
    chk_rd(IDX_STANDBY_STATUS, 8'h00, "ungated status");
    bus(1'b1, IDX_MGMT_CONTROL, 8'h01);
    bus(1'b1, IDX_STANDBY_ENABLE, 8'h10);
    cyc(P - 4);
    `CHK("early expiry", 0, smi_n - n0)
    cyc(P + 10);
    `CHK("expiry", 1, smi_n - n0)
    chk_rd(IDX_STANDBY_STATUS, 8'h10, "standby status");
    cyc(3 * P);
    `CHK("expired stays", 1, smi_n - n0)
    bus(1'b1, IDX_STANDBY_STATUS, 8'h00);
    bus(1'b1, IDX_STANDBY_ENABLE, 8'h00);
    i_host.hit(6'h10);
    cyc(3 * P);
    `CHK("held timer", 1, smi_n - n0)
    chk_rd(IDX_STANDBY_STATUS, 8'h00, "standby clear");
  endtask

  // activity every P-6 cycles (P-4 for a dma acknowledge) must keep a count of 2 from expiring
  task automatic alive(input logic [7:0] act, input int ef);
    int n0;
    n0 = smi_n;
    bus(1'b1, IDX_STANDBY_ENABLE, 8'h10);
    repeat (6)
    begin
      cyc(P - 8);
      if (act[7:6] != 2'b00)
        i_host.dma(act[7]);
      else
        i_host.hit(act[5:0]);
    end
    `CHK("idle expiries", ef, smi_n - n0)
    cyc(2 * P + 6);
    bus(1'b1, IDX_STANDBY_STATUS, 8'h00);
  endtask

  task automatic t_reload;
    int unsigned h;
    alive(8'h10, 0);
    alive(8'h08, 1);
    for (int g = 0; g < GROUPS; g++)
    begin
      h = (g + 1) % GROUPS;
      bus(1'b1, IDX_STANDBY_RELOAD, 8'(1 << (g + RELOAD_GRP_BASE)));
      alive(8'(1 << g), 0);
      alive(8'(1 << h), h == GRP_AUDIO ? 0 : 1);
    end
    bus(1'b1, IDX_STANDBY_RELOAD, 8'h02);
    alive(8'h80, 0);
    bus(1'b1, IDX_STANDBY_RELOAD, 8'h01);
    alive(8'h40, 0);
    alive(8'h80, 1);
  endtask

  task automatic t_freeze;
    int n0;
    bus(1'b1, IDX_MGMT_CONTROL, 8'h03);
    n0 = smi_n;
    bus(1'b1, IDX_STANDBY_ENABLE, 8'h10);
    cyc(4 * P);
    `CHK("frozen expiry", 0, smi_n - n0)
    bus(1'b1, IDX_MGMT_CONTROL, 8'h01);
    cyc(2 * P + 6);
    `CHK("thawed expiry", 1, smi_n - n0)
  endtask

  task automatic give_verdict;
    if (fails == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    resetn = 1'b0;
    ce     = 1'b1;
    hsel   = 1'b0;
    haddr  = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'b010;
    hwdata = 32'h00000000;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    t_regs;
    t_trap;
    t_hold;
    t_expire;
    t_reload;
    t_freeze;
    give_verdict;
  end

  // the full run needs about 3000 cycles
  initial
  begin
    #100_000;
    fails++;
    give_verdict;
  end
endmodule

bind lst_standby_trap lst_standby_trap_chk i_chk (.clk_sys, .resetn, .ce, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .access_hit,
  .system_mgmt_interrupt, .trap_request);
